// File: pkg/ppa_map.vh
`ifndef PPA_MAP_VH
`define PPA_MAP_VH

// Register byte offsets
`define PPA_OFS_IFCFG 8'h00
`define PPA_OFS_ADCFG 8'h04
`define PPA_OFS_FLAGCFG 8'h08
`define PPA_OFS_XFER 8'h0C
`define PPA_OFS_SIZE 8'h10
`define PPA_OFS_THR0 8'h14
`define PPA_OFS_STATUS 8'h24

// Registers reachable from the interface pins
`define PPA_XREG_XFER 8'h80
`define PPA_XREG_SIZE 8'h81

// Interface config fields
`define PPA_CFG_PPMODE 0
`define PPA_CFG_SYNC 1
`define PPA_CFG_CLKINT 2
`define PPA_CFG_NEGEDGE 3
`define PPA_CFG_BIGEND 4
`define PPA_CFG_WIDTH 5
`define PPA_CFG_MUX 7
`define PPA_CFG_MASTER 8
`define PPA_CFG_TSEL 9
`define PPA_CFG_LINES 16

// Thread select sources
`define PPA_TSEL_ADDR 2'h0
`define PPA_TSEL_STATE 2'h1
`define PPA_TSEL_DATA 2'h2

// Address/data config fields
`define PPA_AD_THREAD 0
`define PPA_AD_MADDR 8

// Transfer select and thread config fields
`define PPA_XFER_DIR 8
`define PPA_THR_WM 8

// Reset values
`define PPA_IFCFG_RST 32'h00000000
`define PPA_ADCFG_RST 32'h00000000
`define PPA_FLAGCFG_RST 16'h3210
`define PPA_THR_RST 16'h0000

// Sizes and timing
`define PPA_MIN_LINES 6'h08
`define PPA_SOCK_CAP 8'h80
`define PPA_MCLK_MHZ 100
`define PPA_LCLK_MAX_MHZ 100

`endif

// File: hw/ppa_sync.v
`timescale 1ns/1ps
`default_nettype none

module ppa_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock
    input wire mclk,
    input wire rst,
    input wire ce,
    // Data
    input wire [W-1:0] d,
    output wire [W-1:0] q
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;

genvar i;
generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
        always @(posedge mclk or posedge rst) begin
            if (rst) begin
                s1_ff[i] <= RST_VAL[i];
                s2_ff[i] <= RST_VAL[i];
            end else if (ce) begin
                s1_ff[i] <= d[i];
                s2_ff[i] <= s1_ff[i];
            end
        end
    end
endgenerate

assign q = s2_ff;

endmodule

`default_nettype wire

// File: hw/ppa_top.v
// Operation
// - Eight or more address lines allow processor mode; pins write socket, direction, count
// - Fewer than eight lines force processor mode off and hide registers
// - Two low address lines pick one of four threads and its socket
// - Processor mode uses thread zero, bound to the transfer-select socket
// - Processor mode, address bit 7 high: register access at full address
// - Processor mode, address bit 7 low: data access to programmed socket
// - Mode zero may take the thread from the port state machine
// - Mode zero may take the thread from a config field; socket from thread config
// - A config bit selects asynchronous or synchronous operation
// - Synchronous clock comes from a pin or is generated and driven out
// - Flags come straight from socket fill status, not the state machine
// - Flag follows one thread: empty for read-out, full for written socket
// - Partial flags compare fill level against the thread watermark
// - One config bit makes the port master or slave, never both
// - Address pins are inputs as slave, outputs as master
// - Synchronous mode runs the state machine on the interface clock
// - Interface clock never exceeds 100 MHz
// - Synchronous sampling on rising or falling edge as configured
// - Multibyte words on the pins are little or big endian
// - Data bus width is 8, 16, 24 or 32 bits
// - Multiplexed bus takes the address from data pins under the valid strobe
// - Mode zero spreads sockets modulo four over threads; mode one shares one
`include "ppa_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ppa_top (
    // System
    input wire mclk,
    input wire rst,
    input wire ce,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Interface pins
    input wire pin_clk_in,
    output wire pin_clk_out,
    output wire pin_clk_oe_n,
    input wire pin_cs_n,
    input wire pin_we_n,
    input wire pin_rd_n,
    input wire address_valid_strobe_n,
    input wire [7:0] pin_addr_in,
    output wire [7:0] pin_addr_out,
    output wire pin_addr_oe_n,
    input wire [31:0] pin_data_in,
    output wire [31:0] pin_data_out,
    output wire pin_data_oe_n,
    output wire [3:0] flag_out,
    // Port state machine
    input wire [1:0] sm_thread,
    output wire sm_tick,
    // DMA sockets
    input wire [255:0] sock_level,
    input wire [31:0] sock_dir,
    input wire [31:0] dma_rd_data,
    output wire dma_wr_valid,
    output wire [31:0] dma_wr_data,
    output wire dma_rd_req,
    output wire [1:0] dma_thread,
    output wire [4:0] dma_socket
);

localparam LCLK_HALF = (`PPA_MCLK_MHZ + 2 * `PPA_LCLK_MAX_MHZ - 1) / (2 * `PPA_LCLK_MAX_MHZ);
localparam [3:0] HALF_M1 = LCLK_HALF[3:0] - 4'h1;
localparam [44:0] SYNC_RST = {1'b0, 4'hF, 40'h0};

function [31:0] ppa_fmt;
    input [31:0] d;
    input [1:0] w;
    input big;
    begin
        case (w)
            2'h0: ppa_fmt = {24'h0, d[7:0]};
            2'h1: ppa_fmt = big ? {16'h0, d[7:0], d[15:8]} : {16'h0, d[15:0]};
            2'h2: ppa_fmt = big ? {8'h0, d[7:0], d[15:8], d[23:16]} : {8'h0, d[23:0]};
            default: ppa_fmt = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
        endcase
    end
endfunction

function [31:0] ppa_merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] strb;
    integer k;
    begin
        ppa_merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
                ppa_merge[8*k +: 8] = d[8*k +: 8];
            end
        end
    end
endfunction

// Synchronised pins
wire [44:0] pins_s;
wire clk_s = pins_s[44];
wire cs_n_s = pins_s[43];
wire we_n_s = pins_s[42];
wire rd_n_s = pins_s[41];
wire strobe_n_s = pins_s[40];
wire [7:0] addr_s = pins_s[39:32];
wire [31:0] data_s = pins_s[31:0];

ppa_sync #(.W(45), .RST_VAL(SYNC_RST)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d({pin_clk_in, pin_cs_n, pin_we_n, pin_rd_n, address_valid_strobe_n, pin_addr_in, pin_data_in}),
    .q(pins_s)
);

// Registers
reg [31:0] ifcfg_ff;
reg [31:0] adcfg_ff;
reg [15:0] flagcfg_ff;
reg [8:0] xfer_ff;
reg [31:0] size_ff;
reg [15:0] thr_ff [0:3];
reg [3:0] flag_ff;

wire processor_port_mode_select = ifcfg_ff[`PPA_CFG_PPMODE];
wire sync_mode = ifcfg_ff[`PPA_CFG_SYNC];
wire clk_int = ifcfg_ff[`PPA_CFG_CLKINT];
wire neg_edge = ifcfg_ff[`PPA_CFG_NEGEDGE];
wire big_end = ifcfg_ff[`PPA_CFG_BIGEND];
wire [1:0] bus_w = ifcfg_ff[`PPA_CFG_WIDTH+1:`PPA_CFG_WIDTH];
wire mux_mode = ifcfg_ff[`PPA_CFG_MUX];
wire master = ifcfg_ff[`PPA_CFG_MASTER];
wire [1:0] tsel = ifcfg_ff[`PPA_CFG_TSEL+1:`PPA_CFG_TSEL];
wire lines_ok = ifcfg_ff[`PPA_CFG_LINES+5:`PPA_CFG_LINES] >= `PPA_MIN_LINES;

// Interface clock
reg [3:0] div_ff;
reg clk_gen_ff;
reg lclk_prev_ff;
wire gen_on = sync_mode & clk_int;
wire lclk = clk_int ? clk_gen_ff : clk_s;
wire l_rise = lclk & ~lclk_prev_ff;
wire l_fall = ~lclk & lclk_prev_ff;
wire ev = sync_mode ? (neg_edge ? l_fall : l_rise) : 1'b1;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        div_ff <= 4'h0;
        clk_gen_ff <= 1'b0;
        lclk_prev_ff <= 1'b0;
    end else if (ce) begin
        lclk_prev_ff <= lclk;
        if (!gen_on) begin
            div_ff <= 4'h0;
            clk_gen_ff <= 1'b0;
        end else if (div_ff == HALF_M1) begin
            div_ff <= 4'h0;
            clk_gen_ff <= ~clk_gen_ff;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
end

assign pin_clk_out = clk_gen_ff;
assign pin_clk_oe_n = ~gen_on;
assign sm_tick = ev;

// Thread and socket selection
wire [4:0] thr_sock [0:3];
genvar t;
generate
    for (t = 0; t < 4; t = t + 1) begin : g_thr
        wire [1:0] tn = t;
        assign thr_sock[t] = {thr_ff[t][4:2], tn};
    end
endgenerate

reg [7:0] alat_ff;
wire [7:0] acc_addr = mux_mode ? alat_ff : addr_s;
reg [1:0] act_thr;
always @* begin
    if (processor_port_mode_select) begin
        act_thr = 2'h0;
    end else begin
        case (tsel)
            `PPA_TSEL_ADDR: act_thr = acc_addr[1:0];
            `PPA_TSEL_STATE: act_thr = sm_thread;
            `PPA_TSEL_DATA: act_thr = adcfg_ff[`PPA_AD_THREAD+1:`PPA_AD_THREAD];
            default: act_thr = 2'h0;
        endcase
    end
end
wire [4:0] act_sock = processor_port_mode_select ? xfer_ff[4:0] : thr_sock[act_thr];

// Pin access decode, slave only
reg we_prev_ff;
reg rd_prev_ff;
wire slave_sel = ~master & ~cs_n_s & strobe_n_s;
wire wr_ev = slave_sel & (sync_mode ? (ev & ~we_n_s) : (we_n_s & ~we_prev_ff));
wire rd_ev = slave_sel & (sync_mode ? (ev & ~rd_n_s) : (~rd_n_s & rd_prev_ff));
wire reg_acc = processor_port_mode_select & acc_addr[7];
wire [31:0] wr_word = ppa_fmt(data_s, bus_w, big_end);
reg [31:0] xrd_word;
always @* begin
    case (acc_addr)
        `PPA_XREG_XFER: xrd_word = {23'h0, xfer_ff};
        `PPA_XREG_SIZE: xrd_word = size_ff;
        default: xrd_word = 32'h00000000;
    endcase
end

reg [31:0] pdo_ff;
reg dwr_ff;
reg drd_ff;
reg [31:0] dwd_ff;
reg [1:0] dthr_ff;
reg [4:0] dsock_ff;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        we_prev_ff <= 1'b1;
        rd_prev_ff <= 1'b1;
        alat_ff <= 8'h00;
        pdo_ff <= 32'h00000000;
        dwr_ff <= 1'b0;
        drd_ff <= 1'b0;
        dwd_ff <= 32'h00000000;
        dthr_ff <= 2'h0;
        dsock_ff <= 5'h00;
    end else if (ce) begin
        we_prev_ff <= we_n_s;
        rd_prev_ff <= rd_n_s;
        if (mux_mode && !strobe_n_s && !cs_n_s && ev) begin
            alat_ff <= data_s[7:0];
        end
        dwr_ff <= wr_ev & ~reg_acc;
        drd_ff <= rd_ev & ~reg_acc;
        if ((wr_ev | rd_ev) && !reg_acc) begin
            dthr_ff <= act_thr;
            dsock_ff <= act_sock;
        end
        if (wr_ev && !reg_acc) begin
            dwd_ff <= wr_word;
        end
        if (rd_ev) begin
            pdo_ff <= ppa_fmt(reg_acc ? xrd_word : dma_rd_data, bus_w, big_end);
        end
    end
end

assign dma_wr_valid = dwr_ff;
assign dma_wr_data = dwd_ff;
assign dma_rd_req = drd_ff;
assign dma_thread = dthr_ff;
assign dma_socket = dsock_ff;
assign pin_data_out = pdo_ff;
assign pin_data_oe_n = ~(slave_sel & ~rd_n_s);
assign pin_addr_out = adcfg_ff[`PPA_AD_MADDR+7:`PPA_AD_MADDR];
assign pin_addr_oe_n = ~master;

// Flags from socket status
generate
    for (t = 0; t < 4; t = t + 1) begin : g_flag
        wire [1:0] fthr = flagcfg_ff[4*t +: 2];
        wire part = flagcfg_ff[4*t+2];
        wire [4:0] fs = processor_port_mode_select ? xfer_ff[4:0] : thr_sock[fthr];
        wire [7:0] lvl = sock_level[8*fs +: 8];
        wire [7:0] wm = thr_ff[processor_port_mode_select ? 2'h0 : fthr][`PPA_THR_WM+7:`PPA_THR_WM];
        wire fill_dir = sock_dir[fs];
        wire nxt_flag = fill_dir ? (part ? (lvl >= `PPA_SOCK_CAP - wm) : (lvl == `PPA_SOCK_CAP))
                                 : (part ? (lvl <= wm) : (lvl == 8'h00));
        always @(posedge mclk or posedge rst) begin
            if (rst) begin
                flag_ff[t] <= 1'b0;
            end else if (ce && ev) begin
                flag_ff[t] <= nxt_flag;
            end
        end
    end
endgenerate

assign flag_out = flag_ff;

// AXI4-Lite slave
reg aw_ff;
reg w_ff;
reg [7:0] awa_ff;
reg [31:0] wd_ff;
reg [3:0] ws_ff;
reg bv_ff;
reg [1:0] br_ff;
reg rv_ff;
reg [31:0] rd_ff;
reg [1:0] rr_ff;

assign s_axi_awready = ce & ~aw_ff;
assign s_axi_wready = ce & ~w_ff;
assign s_axi_arready = ce & ~rv_ff;
assign s_axi_bvalid = bv_ff;
assign s_axi_bresp = br_ff;
assign s_axi_rvalid = rv_ff;
assign s_axi_rdata = rd_ff;
assign s_axi_rresp = rr_ff;

wire do_wr = aw_ff & w_ff & ~bv_ff;
wire wr_thr = awa_ff >= `PPA_OFS_THR0 && awa_ff < `PPA_OFS_STATUS && awa_ff[1:0] == 2'h0;
wire [1:0] wr_ti = awa_ff[3:2] - 2'h1;
wire [31:0] nxt_ifcfg = ppa_merge(ifcfg_ff, wd_ff, ws_ff);
wire nxt_lines_ok = nxt_ifcfg[`PPA_CFG_LINES+5:`PPA_CFG_LINES] >= `PPA_MIN_LINES;
wire [31:0] nxt_thr = ppa_merge({16'h0, thr_ff[wr_ti]}, wd_ff, ws_ff) & 32'h0000FF1F;
wire [31:0] nxt_flagcfg = ppa_merge({16'h0, flagcfg_ff}, wd_ff, ws_ff);
wire [31:0] nxt_xfer = ppa_merge({23'h0, xfer_ff}, wd_ff, ws_ff);

reg [31:0] ard;
reg aok;
wire ar_thr = s_axi_araddr >= `PPA_OFS_THR0 && s_axi_araddr < `PPA_OFS_STATUS && s_axi_araddr[1:0] == 2'h0;
wire [1:0] ar_ti = s_axi_araddr[3:2] - 2'h1;
always @* begin
    ard = 32'h00000000;
    aok = 1'b1;
    if (ar_thr) begin
        ard = {16'h0, thr_ff[ar_ti]};
    end else begin
        case (s_axi_araddr)
            `PPA_OFS_IFCFG: ard = ifcfg_ff;
            `PPA_OFS_ADCFG: ard = adcfg_ff;
            `PPA_OFS_FLAGCFG: ard = {16'h0, flagcfg_ff};
            `PPA_OFS_XFER: ard = {23'h0, xfer_ff};
            `PPA_OFS_SIZE: ard = size_ff;
            `PPA_OFS_STATUS: ard = {20'h0, flag_ff, 1'b0, act_thr, act_sock};
            default: aok = 1'b0;
        endcase
    end
end

integer j;
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        awa_ff <= 8'h00;
        wd_ff <= 32'h00000000;
        ws_ff <= 4'h0;
        bv_ff <= 1'b0;
        br_ff <= 2'h0;
        rv_ff <= 1'b0;
        rd_ff <= 32'h00000000;
        rr_ff <= 2'h0;
        ifcfg_ff <= `PPA_IFCFG_RST;
        adcfg_ff <= `PPA_ADCFG_RST;
        flagcfg_ff <= `PPA_FLAGCFG_RST;
        xfer_ff <= 9'h000;
        size_ff <= 32'h00000000;
        for (j = 0; j < 4; j = j + 1) begin
            thr_ff[j] <= `PPA_THR_RST | j[15:0];
        end
    end else if (ce) begin
        if (s_axi_awvalid && !aw_ff) begin
            aw_ff <= 1'b1;
            awa_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff) begin
            w_ff <= 1'b1;
            wd_ff <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
        end
        if (s_axi_bready && bv_ff) begin
            bv_ff <= 1'b0;
        end
        if (do_wr) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bv_ff <= 1'b1;
            br_ff <= 2'h0;
            if (wr_thr) begin
                thr_ff[wr_ti] <= nxt_thr[15:0];
            end else begin
                case (awa_ff)
                    `PPA_OFS_IFCFG: begin
                        ifcfg_ff <= nxt_ifcfg & {31'h7FFFFFFF, nxt_lines_ok};
                    end
                    `PPA_OFS_ADCFG: adcfg_ff <= ppa_merge(adcfg_ff, wd_ff, ws_ff);
                    `PPA_OFS_FLAGCFG: flagcfg_ff <= nxt_flagcfg[15:0];
                    `PPA_OFS_XFER: xfer_ff <= nxt_xfer[8:0];
                    `PPA_OFS_SIZE: size_ff <= ppa_merge(size_ff, wd_ff, ws_ff);
                    default: br_ff <= 2'h2;
                endcase
            end
        end
        if (!lines_ok && !(do_wr && awa_ff == `PPA_OFS_IFCFG)) begin
            ifcfg_ff[`PPA_CFG_PPMODE] <= 1'b0;
        end
        if (wr_ev && reg_acc) begin
            if (acc_addr == `PPA_XREG_XFER) begin
                xfer_ff <= wr_word[8:0];
            end else if (acc_addr == `PPA_XREG_SIZE) begin
                size_ff <= wr_word;
            end
        end
        if (rv_ff && s_axi_rready) begin
            rv_ff <= 1'b0;
        end else if (s_axi_arvalid && !rv_ff) begin
            rv_ff <= 1'b1;
            rd_ff <= ard;
            rr_ff <= aok ? 2'h0 : 2'h2;
        end
    end
end

endmodule

`default_nettype wire

// File: bench/ppa_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_properties (
    // Clock and bus
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Pins and sockets
    input wire logic pin_clk_out,
    input wire logic pin_clk_oe_n,
    input wire logic pin_addr_oe_n,
    input wire logic pin_data_oe_n,
    input wire logic [3:0] flag_out,
    input wire logic sm_tick,
    input wire logic dma_wr_valid,
    input wire logic dma_rd_req
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_clk_gen_toggles: assert property (
        (!pin_clk_oe_n && ce) ##1 !pin_clk_oe_n |-> pin_clk_out != $past(pin_clk_out))
        else $error("driven clock not toggling");
    a_flag_on_tick: assert property (!sm_tick |=> $stable(flag_out))
        else $error("flags moved without tick");
    a_master_ignores: assert property (!pin_addr_oe_n [*3] |-> !dma_wr_valid && !dma_rd_req)
        else $error("pin access served as master");
    a_data_slave_only: assert property (!pin_data_oe_n |-> pin_addr_oe_n)
        else $error("data driven as master");
    a_pulse_single: assert property (dma_wr_valid || dma_rd_req |=> !dma_wr_valid && !dma_rd_req)
        else $error("data pulse too long");
    a_no_both_pulses: assert property (!(dma_wr_valid && dma_rd_req))
        else $error("read and write together");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_pin_write: cover property (dma_wr_valid);
    c_pin_read: cover property (dma_rd_req);
endmodule
bind ppa_top ppa_properties u_props (.mclk, .rst, .ce, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .pin_clk_out, .pin_clk_oe_n, .pin_addr_oe_n, .pin_data_oe_n, .flag_out,
    .sm_tick, .dma_wr_valid, .dma_rd_req);
`default_nettype wire

// File: bench/ppa_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppa_ext_model (
    // Clocks and strobes
    input wire logic mclk,
    output logic pin_clk_in = 1'b0,
    output logic pin_cs_n = 1'b1,
    output logic pin_we_n = 1'b1,
    output logic pin_rd_n = 1'b1,
    output logic address_valid_strobe_n = 1'b1,
    // Address and data
    output logic [7:0] pin_addr_in = 8'h00,
    output logic [31:0] pin_data_in = 32'h00000000,
    input wire logic [31:0] pin_data_out
);
    // Processor write; the clock runs only inside the frame
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sy);
        @(posedge mclk);
        pin_addr_in <= a;
        pin_data_in <= d;
        pin_cs_n <= 1'b0;
        pin_we_n <= 1'b0;
        if (sy) begin
            #3 pin_clk_in = 1'b1;
            #40 pin_clk_in = 1'b0;
            #40;
        end
        repeat (6) @(posedge mclk);
        pin_we_n <= 1'b1;
        repeat (4) @(posedge mclk);
        pin_cs_n <= 1'b1;
        pin_addr_in <= ~a;
        pin_data_in <= ~d;
    endtask
    // Multiplexed write: address phase on the data pins first
    task automatic mwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        pin_data_in <= {24'h0, a};
        pin_cs_n <= 1'b0;
        address_valid_strobe_n <= 1'b0;
        repeat (4) @(posedge mclk);
        address_valid_strobe_n <= 1'b1;
        wr(~a, d, 1'b0);
    endtask
    // Processor read of one word
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge mclk);
        pin_addr_in <= a;
        pin_cs_n <= 1'b0;
        pin_rd_n <= 1'b0;
        repeat (6) @(posedge mclk);
        q = pin_data_out;
        pin_rd_n <= 1'b1;
        pin_cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: bench/programmable_parallel_port_addressing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module programmable_parallel_port_addressing_tb_top;
    logic mclk, rst = 1'b1, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, sock_dir = 32'h0, dma_rd_data = 32'h13579BDF, q;
    logic [1:0] sm_thread = 2'h0, r;
    logic [255:0] sock_level = 256'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_clk_in, pin_clk_out;
    wire pin_clk_oe_n, pin_cs_n, pin_we_n, pin_rd_n, address_valid_strobe_n, pin_addr_oe_n, pin_data_oe_n;
    wire sm_tick, dma_wr_valid, dma_rd_req;
    wire [1:0] s_axi_bresp, s_axi_rresp, dma_thread;
    wire [31:0] s_axi_rdata, pin_data_in, pin_data_out, dma_wr_data;
    wire [7:0] pin_addr_in, pin_addr_out;
    wire [3:0] flag_out;
    wire [4:0] dma_socket;
    int errors = 0, n_tests = 0, cyc = 0, wr_cnt = 0, n, t;
    ppa_top DUT (.mclk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_clk_in, .pin_clk_out,
        .pin_clk_oe_n, .pin_cs_n, .pin_we_n, .pin_rd_n, .address_valid_strobe_n, .pin_addr_in, .pin_addr_out,
        .pin_addr_oe_n, .pin_data_in, .pin_data_out, .pin_data_oe_n, .flag_out, .sm_thread, .sm_tick, .sock_level,
        .sock_dir, .dma_rd_data, .dma_wr_valid, .dma_wr_data, .dma_rd_req, .dma_thread, .dma_socket);
    ppa_ext_model p (.mclk, .pin_clk_in, .pin_cs_n, .pin_we_n, .pin_rd_n, .address_valid_strobe_n, .pin_addr_in,
        .pin_data_in, .pin_data_out);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        wr_cnt <= wr_cnt + int'(dma_wr_valid === 1'b1);
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One register access; data compared on reads, response on both
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tr, v;
        v = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!v) begin
            @(negedge mclk);
            ta = s_axi_awready === 1'b1;
            tw = s_axi_wready === 1'b1;
            tr = s_axi_arready === 1'b1;
            v = w ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge mclk);
            s_axi_awvalid <= s_axi_awvalid & !ta;
            s_axi_wvalid <= s_axi_wvalid & !tw;
            s_axi_arvalid <= s_axi_arvalid & !tr;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!w)
            `CHK("rdata", d, q)
        `CHK("resp", er, r)
    endtask
    task automatic pwr(input logic [7:0] a, input logic sy, input logic [1:0] et, input logic [4:0] es,
        input logic [31:0] ed);
        p.wr(a, 32'h44332211, sy);
        @(negedge mclk);
        `CHK("thread", et, dma_thread)
        `CHK("socket", es, dma_socket)
        `CHK("wdata", ed, dma_wr_data)
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        axi(1'b0, 8'h00, 32'h00000000, 2'h0);
        axi(1'b0, 8'h08, 32'h00003210, 2'h0);
        axi(1'b0, 8'h40, 32'h00000000, 2'h2);
        axi(1'b1, 8'h00, 32'h00040001, 2'h0);
        axi(1'b0, 8'h00, 32'h00040000, 2'h0);
        p.wr(8'h80, 32'h0000001F, 1'b0);
        axi(1'b0, 8'h0C, 32'h00000000, 2'h0);
        axi(1'b1, 8'h00, 32'h00080061, 2'h0);
        p.wr(8'h80, 32'h00000105, 1'b0);
        p.wr(8'h81, 32'h00000040, 1'b0);
        axi(1'b0, 8'h0C, 32'h00000105, 2'h0);
        axi(1'b0, 8'h10, 32'h00000040, 2'h0);
        pwr(8'h03, 1'b0, 2'h0, 5'h05, 32'h44332211);
        p.rd(8'h00, q);
        `CHK("pin read", 32'h13579BDF, q)
        p.rd(8'h80, q);
        `CHK("pin reg read", 32'h00000105, q)
        axi(1'b1, 8'h00, 32'h00080060, 2'h0);
        for (t = 0; t < 4; t++)
            axi(1'b1, 8'(8'h14 + 4 * t), 32'h00000004, 2'h0);
        for (t = 0; t < 4; t++)
            pwr(8'(t), 1'b0, 2'(t), 5'(4 + t), 32'h44332211);
        for (t = 0; t < 4; t++) begin
            axi(1'b1, 8'h00, 32'h00080000 | (t << 5), 2'h0);
            pwr(8'h00, 1'b0, 2'h0, 5'h04, 32'h44332211 & (32'hFFFFFFFF >> (8 * (3 - t))));
        end
        axi(1'b1, 8'h00, 32'h00080030, 2'h0);
        pwr(8'h00, 1'b0, 2'h0, 5'h04, 32'h00001122);
        axi(1'b1, 8'h00, 32'h00080260, 2'h0);
        sm_thread <= 2'h2;
        pwr(8'h01, 1'b0, 2'h2, 5'h06, 32'h44332211);
        axi(1'b1, 8'h04, 32'h00000003, 2'h0);
        axi(1'b1, 8'h00, 32'h00080460, 2'h0);
        pwr(8'h01, 1'b0, 2'h3, 5'h07, 32'h44332211);
        axi(1'b1, 8'h00, 32'h00080060, 2'h0);
        sock_dir <= 32'h000000A0;
        sock_level <= 256'h7F03800000000000;
        repeat (4) @(negedge mclk);
        `CHK("flags", 4'h3, flag_out)
        axi(1'b1, 8'h08, 32'h00007210, 2'h0);
        axi(1'b1, 8'h20, 32'h00000204, 2'h0);
        repeat (4) @(negedge mclk);
        `CHK("flags", 4'hB, flag_out)
        axi(1'b1, 8'h08, 32'h00007212, 2'h0);
        repeat (2) @(negedge mclk);
        `CHK("flags", 4'hA, flag_out)
        axi(1'b1, 8'h00, 32'h000800E0, 2'h0);
        p.mwr(8'h02, 32'h44332211);
        @(negedge mclk);
        `CHK("mux thread", 2'h2, dma_thread)
        `CHK("mux socket", 5'h06, dma_socket)
        for (t = 0; t < 2; t++) begin
            axi(1'b1, 8'h00, 32'h00080062 | (t << 3), 2'h0);
            pwr(8'(2 - t), 1'b1, 2'(2 - t), 5'(6 - t), 32'h44332211);
        end
        axi(1'b1, 8'h00, 32'h00080066, 2'h0);
        repeat (3) @(negedge mclk);
        `CHK("clock enable", 1'b0, pin_clk_oe_n)
        axi(1'b1, 8'h04, 32'h00005A00, 2'h0);
        axi(1'b1, 8'h00, 32'h00080160, 2'h0);
        n = wr_cnt;
        p.wr(8'h00, 32'h00000001, 1'b0);
        @(negedge mclk);
        `CHK("addr enable", 1'b0, pin_addr_oe_n)
        `CHK("addr out", 8'h5A, pin_addr_out)
        `CHK("writes", n, wr_cnt)
        final_report();
    end
endmodule
`default_nettype wire
